// ---- core/rx_status_fifo.sv ----
// Two-entry receive buffer holding data and per-frame status
`timescale 1ns/1ps
module rx_status_fifo
    import uart_rx_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    // Write side
    input  wire logic             wr_valid,
    input  wire logic [ENT_W-1:0] wr_data,
    output logic                  wr_ready,
    // Read side
    input  wire logic             rd_pop,
    output logic                  rd_valid,
    output logic [ENT_W-1:0]      rd_head,
    output logic [1:0]            count
);

    logic [ENT_W-1:0] mem_q [2];
    logic [ENT_W-1:0] mem_d [2];
    logic             wp_q, wp_d;
    logic             rp_q, rp_d;
    logic [1:0]       cnt_q, cnt_d;
    logic             do_wr, do_rd;

    assign wr_ready = (cnt_q != 2'h2);
    assign rd_valid = (cnt_q != 2'h0);
    assign rd_head  = mem_q[rp_q];
    assign count    = cnt_q;
    assign do_wr    = wr_valid && wr_ready;
    assign do_rd    = rd_pop && rd_valid;

    always_comb begin
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        if (flush) begin
            wp_d  = 1'b0;
            rp_d  = 1'b0;
            cnt_d = 2'h0;
        end else begin
            if (do_wr) begin
                mem_d[wp_q] = wr_data;
                wp_d        = ~wp_q;
            end
            if (do_rd) begin
                rp_d = ~rp_q;
            end
            cnt_d = cnt_q + {1'b0, do_wr} - {1'b0, do_rd};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

endmodule : rx_status_fifo

// ---- core/uart_rx.sv ----
// Serial receiver with oversampled start detection and status buffer
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
module uart_rx
    import uart_rx_pkg::*;
(
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    // Serial line
    input  wire logic        RXD_PIN,
    input  wire logic        SAMPLE_TICK,
    output logic             RX_OWNS_PIN,
    // Interrupt request
    output logic             RXC_IRQ
);

    // ==========================================================
    // Declarations
    logic             sync1_q, sync2_q;
    rx_state_t        state_q, state_d;
    logic [4:0]       cnt_q, cnt_d;
    logic [1:0]       votes_q, votes_d;
    logic [3:0]       idx_q, idx_d;
    logic [8:0]       shift_q, shift_d;
    logic             par_q, par_d;
    logic             prev_q, prev_d;
    logic             pend_q, pend_d;
    logic [ENT_W-1:0] pword_q, pword_d;
    logic             ovr_q, ovr_d;
    logic             ack_q, ack_d;
    logic [31:0]      dat_q, dat_d;
    logic             rx_complete_irq_enable_q, rx_complete_irq_enable_d, en_q, en_d, csz2_q, csz2_d, dsp_q, dsp_d;
    logic [7:0]       fmt_q, fmt_d;
    logic [2:0]       csz;
    logic [3:0]       nbits;
    logic [4:0]       spb, vfirst, vlast, samp;
    logic             line, vote, start_ok, frame_done, req, pop;
    logic             fifo_wr, fifo_ready, rx_complete_flag;
    logic [ENT_W-1:0] fifo_wdata, head;
    logic [1:0]       fifo_count;

    // ==========================================================
    // Line synchroniser
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= RXD_PIN;
            sync2_q <= sync1_q;
        end
    end
    assign line = sync2_q;

    // ==========================================================
    // Frame format decode
    assign csz    = {csz2_q, fmt_q[FMT_CSZ_HI:FMT_CSZ_LO]};
    assign nbits  = (csz == CSZ_NINE) ? BITS_NINE : BITS_BASE + {2'h0, csz[1:0]};
    assign spb    = dsp_q ? SPB_DOUBLE : SPB_NORMAL;
    assign vfirst = dsp_q ? VOTE_DOUBLE : VOTE_NORMAL;
    assign vlast  = vfirst + VOTE_SPAN;
    assign samp   = (cnt_q >= spb) ? 5'h01 : cnt_q + 5'h01;
    assign vote   = (votes_q[1] & votes_q[0]) | (votes_q[1] & line) | (votes_q[0] & line);

    // ==========================================================
    // Receive state machine
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        votes_d    = votes_q;
        idx_d      = idx_q;
        shift_d    = shift_q;
        par_d      = par_q;
        prev_d     = prev_q;
        start_ok   = 1'b0;
        frame_done = 1'b0;
        if (SAMPLE_TICK) begin
            prev_d = line;
            if (state_q != RX_IDLE) begin
                cnt_d = samp;
                if (samp == vfirst || samp == vfirst + 5'h01) begin
                    votes_d = {votes_q[0], line};
                end
            end
            unique case (state_q)
                RX_IDLE: begin
                    if (prev_q && !line) begin
                        state_d = RX_START;
                        cnt_d   = 5'h01;
                        shift_d = 9'h000;
                        par_d   = 1'b0;
                        idx_d   = 4'h0;
                    end
                end
                RX_START: begin
                    if (samp == vlast) begin
                        if (vote) begin
                            state_d = RX_IDLE;
                        end else begin
                            start_ok = 1'b1;
                        end
                    end else if (samp == spb) begin
                        state_d = RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (samp == vlast) begin
                        shift_d[idx_q] = vote;
                        par_d          = par_q ^ vote;
                    end else if (samp == spb) begin
                        if (idx_q == nbits - 4'h1) begin
                            state_d = fmt_q[FMT_PAR_EN] ? RX_PARITY : RX_STOP;
                        end else begin
                            idx_d = idx_q + 4'h1;
                        end
                    end
                end
                RX_PARITY: begin
                    if (samp == vlast) begin
                        par_d = par_q ^ vote;
                    end else if (samp == spb) begin
                        state_d = RX_STOP;
                    end
                end
                RX_STOP: begin
                    // Only the first stop bit is looked at; the line is free right after its vote
                    if (samp == vlast) begin
                        frame_done = 1'b1;
                        state_d    = RX_IDLE;
                    end
                end
            endcase
        end
        if (!en_q) begin
            state_d = RX_IDLE;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_q <= RX_IDLE;
            cnt_q   <= 5'h00;
            votes_q <= 2'h0;
            idx_q   <= 4'h0;
            shift_q <= 9'h000;
            par_q   <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            votes_q <= votes_d;
            idx_q   <= idx_d;
            shift_q <= shift_d;
            par_q   <= par_d;
            prev_q  <= prev_d;
        end
    end

    // ==========================================================
    // Shift register hand-off and overrun
    assign fifo_wr    = pend_q && en_q;
    assign fifo_wdata = {pword_q[ENT_PE], ovr_q, pword_q[ENT_FE:0]};

    always_comb begin
        pend_d  = pend_q;
        pword_d = pword_q;
        ovr_d   = ovr_q;
        if (fifo_wr && fifo_ready) begin
            pend_d = 1'b0;
            ovr_d  = 1'b0;
        end
        if (start_ok && pend_q && !fifo_ready) begin
            // Waiting frame is lost: the new one will overwrite the shift register
            pend_d = 1'b0;
            ovr_d  = 1'b1;
        end
        if (frame_done) begin
            pend_d  = 1'b1;
            pword_d = {fmt_q[FMT_PAR_EN] & (par_q ^ fmt_q[FMT_PAR_ODD]), 1'b0, ~vote, shift_q};
        end
        if (!en_q) begin
            pend_d = 1'b0;
            ovr_d  = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pend_q  <= 1'b0;
            pword_q <= '0;
            ovr_q   <= 1'b0;
        end else begin
            pend_q  <= pend_d;
            pword_q <= pword_d;
            ovr_q   <= ovr_d;
        end
    end

    rx_status_fifo u_fifo (
        .clk      (REF_CLK),
        .rst      (RST),
        .flush    (!en_q),
        .wr_valid (fifo_wr),
        .wr_data  (fifo_wdata),
        .wr_ready (fifo_ready),
        .rd_pop   (pop),
        .rd_valid (rx_complete_flag),
        .rd_head  (head),
        .count    (fifo_count)
    );

    // ==========================================================
    // Register bus
    assign req = WB_CYC_I && WB_STB_I && !ack_q;
    assign pop = req && !WB_WE_I && (WB_ADR_I == ADR_DATA);

    always_comb begin
        ack_d   = req;
        dat_d   = dat_q;
        rx_complete_irq_enable_d = rx_complete_irq_enable_q;
        en_d    = en_q;
        csz2_d  = csz2_q;
        dsp_d   = dsp_q;
        fmt_d   = fmt_q;
        if (req && !WB_WE_I) begin
            dat_d = 32'h0000_0000;
            unique case (WB_ADR_I)
                ADR_DATA:    dat_d[7:0] = head[7:0] & {8{rx_complete_flag}};
                ADR_STATUS: begin
                    dat_d[ST_RXC]    = rx_complete_flag;
                    dat_d[ST_FE]     = rx_complete_flag & head[ENT_FE];
                    dat_d[ST_DOR]    = rx_complete_flag & head[ENT_DOR];
                    dat_d[ST_PE]     = rx_complete_flag & head[ENT_PE] & fmt_q[FMT_PAR_EN];
                    dat_d[ST_DSPEED] = dsp_q;
                end
                ADR_CONTROL: begin
                    dat_d[CTL_RX_COMPLETE_IRQ_ENABLE] = rx_complete_irq_enable_q;
                    dat_d[CTL_RECEIVER_ENABLE]  = en_q;
                    dat_d[CTL_CSZ2]  = csz2_q;
                    dat_d[CTL_RX9]   = rx_complete_flag & head[8];
                end
                ADR_FORMAT:  dat_d[7:0] = fmt_q;
                default:     dat_d = 32'h0000_0000;
            endcase
        end
        if (req && WB_WE_I && WB_SEL_I[0]) begin
            unique case (WB_ADR_I)
                ADR_STATUS:  dsp_d = WB_DAT_I[ST_DSPEED];
                ADR_CONTROL: begin
                    rx_complete_irq_enable_d = WB_DAT_I[CTL_RX_COMPLETE_IRQ_ENABLE];
                    en_d    = WB_DAT_I[CTL_RECEIVER_ENABLE];
                    csz2_d  = WB_DAT_I[CTL_CSZ2];
                end
                ADR_FORMAT:  fmt_d = WB_DAT_I[7:0];
                default:     fmt_d = fmt_q;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ack_q   <= 1'b0;
            dat_q   <= 32'h0000_0000;
            rx_complete_irq_enable_q <= CTL_RESET[CTL_RX_COMPLETE_IRQ_ENABLE];
            en_q    <= CTL_RESET[CTL_RECEIVER_ENABLE];
            csz2_q  <= CTL_RESET[CTL_CSZ2];
            dsp_q   <= DSPEED_RST;
            fmt_q   <= FMT_RESET;
        end else begin
            ack_q   <= ack_d;
            dat_q   <= dat_d;
            rx_complete_irq_enable_q <= rx_complete_irq_enable_d;
            en_q    <= en_d;
            csz2_q  <= csz2_d;
            dsp_q   <= dsp_d;
            fmt_q   <= fmt_d;
        end
    end

    assign WB_ACK_O    = ack_q;
    assign WB_DAT_O    = dat_q;
    assign RX_OWNS_PIN = en_q;
    assign RXC_IRQ     = rx_complete_irq_enable_q & rx_complete_flag;

    // ==========================================================
    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence read_of(logic [3:0] a);
        req && !WB_WE_I && WB_ADR_I == a;
    endsequence
    sequence write_of(logic [3:0] a);
        req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == a;
    endsequence
    sequence last_frame_read;
        read_of(ADR_DATA) ##0 fifo_count == 2'h1 ##0 !(fifo_wr && fifo_ready);
    endsequence

    chk_ack_single:     assert property (req |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack not a single pulse");
    chk_irq_drops:      assert property (last_frame_read |=> !RXC_IRQ)
        else $error("irq stays after last frame read");
    chk_rxc_on_write:   assert property (en_q && fifo_wr && fifo_ready |=> rx_complete_flag)
        else $error("complete flag low after buffer write");
    chk_flush_disable:  assert property (!en_q |=> !rx_complete_flag && state_q == RX_IDLE && !pend_q)
        else $error("disable did not flush");
    chk_pe_masked:      assert property (read_of(ADR_STATUS) ##0 !fmt_q[FMT_PAR_EN] |=> !WB_DAT_O[ST_PE])
        else $error("parity error visible while checking off");
    chk_status_keeps:   assert property (write_of(ADR_STATUS) ##0 en_q && !fifo_wr && !start_ok
                                         |=> $stable(head) && $stable(ovr_q))
        else $error("status write altered flags");
    chk_start_reject:   assert property (en_q && state_q == RX_START && SAMPLE_TICK && samp == vlast && vote
                                         |=> state_q == RX_IDLE)
        else $error("noisy start not rejected");
    chk_overrun_set:    assert property (en_q && start_ok && pend_q && !fifo_ready |=> ovr_q && !pend_q)
        else $error("overrun not flagged");
    chk_overrun_clear:  assert property (en_q && fifo_wr && fifo_ready && !frame_done
                                         |=> !ovr_q && $past(ovr_q) == head[ENT_DOR] || fifo_count == 2'h2)
        else $error("overrun not cleared on transfer");
    chk_stop_fe:        assert property (en_q && frame_done |=> pend_q && pword_q[ENT_FE] == !$past(vote))
        else $error("frame error does not follow stop bit");

endmodule : uart_rx

// ---- core/uart_rx_pkg.sv ----
// Constants, register map and types of the serial receive block
// Notes on behaviour
// - Ninth bit and error flags travel with each frame
// - Receive-complete flag set while buffer holds data
// - Clearing the enable flushes the receive buffer
// - Interrupt request is level, enable and flag
// - Status writes leave error flags unchanged
// - Error flags raise no interrupt request
// - Frame error follows first stop bit only
// - Overrun: buffer full, frame waiting, new start
// - Overrun clears on successful buffer transfer
// - Parity error reads zero when checking disabled
// - Parity computed, odd or even, stored per frame
// - Parity error set only when checking was enabled
// - Disable is immediate, reception abandoned, pin released
// - Sixteen samples per bit, eight in double speed
// - Falling edge on idle line starts detection
// - Start vote on samples 8-10 or 4-6
// - Bit timing realigned at every start bit
// - Each bit decided by centre three-sample majority
// - Frame moves to buffer after first stop bit
// - Unused upper data bits read as zero
// - Enable hands the receive pin to the receiver
package uart_rx_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [3:0] ADR_DATA    = 4'h0;
    localparam logic [3:0] ADR_STATUS  = 4'h4;
    localparam logic [3:0] ADR_CONTROL = 4'h8;
    localparam logic [3:0] ADR_FORMAT  = 4'hC;

    // ==========================================================
    // Field positions
    localparam int ST_RXC      = 7;
    localparam int ST_FE       = 4;
    localparam int ST_DOR      = 3;
    localparam int ST_PE       = 2;
    localparam int ST_DSPEED   = 1;
    localparam int CTL_RX_COMPLETE_IRQ_ENABLE   = 7;
    localparam int CTL_RECEIVER_ENABLE    = 4;
    localparam int CTL_CSZ2    = 2;
    localparam int CTL_RX9     = 1;
    localparam int FMT_PAR_EN  = 5;
    localparam int FMT_PAR_ODD = 4;
    localparam int FMT_STOP2   = 3;
    localparam int FMT_CSZ_HI  = 2;
    localparam int FMT_CSZ_LO  = 1;

    // ==========================================================
    // Reset values and codes
    localparam logic [7:0] CTL_RESET   = 8'h00;
    localparam logic [7:0] FMT_RESET   = 8'h06;
    localparam logic       DSPEED_RST  = 1'b0;
    localparam logic [2:0] CSZ_NINE    = 3'h7;
    localparam logic [3:0] BITS_BASE   = 4'h5;
    localparam logic [3:0] BITS_NINE   = 4'h9;

    // ==========================================================
    // Oversampling
    localparam logic [4:0] SPB_NORMAL  = 5'h10;
    localparam logic [4:0] SPB_DOUBLE  = 5'h08;
    localparam logic [4:0] VOTE_NORMAL = 5'h08;
    localparam logic [4:0] VOTE_DOUBLE = 5'h04;
    localparam logic [4:0] VOTE_SPAN   = 5'h02;

    // ==========================================================
    // Buffer entry layout: data [8:0], then flags
    localparam int ENT_W   = 12;
    localparam int ENT_FE  = 9;
    localparam int ENT_DOR = 10;
    localparam int ENT_PE  = 11;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

endpackage : uart_rx_pkg

// ---- testbench/serial_tx_model.sv ----
// Behavioural remote transmitter driving the serial receive line
`timescale 1ns/1ps
module serial_tx_model (
    // Timing
    input  wire logic clk,
    input  wire logic tick,
    // Serial line
    output logic      line
);
    initial line = 1'h1;

    // ==========================================================
    // Bit timing: each level lasts a whole number of sample ticks
    task automatic hold(input logic v, input int n);
        line <= v;
        repeat (n) @(posedge clk iff tick);
    endtask : hold

    // Start, data LSB first, optional parity, one stop; one idle tick after, so that
    // back-to-back frames never drive the line twice at one edge
    task automatic send(input logic [8:0] d, input int nb, input logic par, input logic odd,
                        input logic bad, input logic stp, input int spb);
        logic p;
        p = ^(d & ((9'h001 << nb) - 9'h001)) ^ odd ^ bad;
        hold(1'h0, spb);
        for (int i = 0; i < nb; i++) begin
            hold(d[i], spb);
        end
        if (par) begin
            hold(p, spb);
        end
        hold(stp, spb);
        hold(1'h1, 1);
    endtask : send

    // Short low pulse that must not pass the start vote
    task automatic glitch(input int n);
        hold(1'h0, n);
        hold(1'h1, 16);
    endtask : glitch
endmodule : serial_tx_model

// ---- testbench/uart_rx_tb_top.sv ----
// Self-checking testbench of the serial receiver
`timescale 1ns/1ps
module uart_rx_tb_top
    import uart_rx_pkg::*;
;
    logic        REF_CLK, RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
    logic [3:0]  WB_ADR_I, WB_SEL_I;
    logic [31:0] WB_DAT_I, WB_DAT_O, rd;
    logic        RXD_PIN, SAMPLE_TICK, RX_OWNS_PIN, RXC_IRQ;
    int          errors, checks_done, cycles;

    typedef struct packed {
        logic [2:0] csz;
        logic       par, odd, bad, stp, ds;
        logic [8:0] d;
        logic [7:0] est, edat;
        logic       e9;
    } row_t;

    // ==========================================================
    // Ordinary frames: size, parity, stop level, speed, data; expected status, data, ninth bit
    row_t rows [6] = '{
        '{3'h3, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 9'h0A5, 8'h80, 8'hA5, 1'h0},
        '{3'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 9'h035, 8'h80, 8'h15, 1'h0},
        '{3'h7, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 9'h13C, 8'h84, 8'h3C, 1'h1},
        '{3'h2, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 9'h0C3, 8'h92, 8'h43, 1'h0},
        '{3'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 9'h02A, 8'h80, 8'h2A, 1'h0},
        '{3'h3, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 9'h000, 8'h82, 8'h00, 1'h0}};

    uart_rx i_dut (.REF_CLK(REF_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
                   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
                   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .RXD_PIN(RXD_PIN),
                   .SAMPLE_TICK(SAMPLE_TICK), .RX_OWNS_PIN(RX_OWNS_PIN), .RXC_IRQ(RXC_IRQ));
    serial_tx_model i_tx (.clk(REF_CLK), .tick(SAMPLE_TICK), .line(RXD_PIN));

    // ==========================================================
    // Clock, oversample tick every second cycle, timeout
    initial begin
        REF_CLK = 1'h0;
        forever #50 REF_CLK = ~REF_CLK;
    end

    always @(posedge REF_CLK) begin
        SAMPLE_TICK <= ~SAMPLE_TICK;
        cycles++;
        if (cycles == 30000) begin
            errors++;
            test_done();
        end
    end

    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Classic cycle: hold until ack is sampled, take data at that edge, then idle one cycle
    task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] w);
        WB_CYC_I <= 1'h1;
        WB_STB_I <= 1'h1;
        WB_WE_I  <= we;
        WB_ADR_I <= a;
        WB_DAT_I <= {24'h000000, w};
        do begin
            @(posedge REF_CLK);
        end while (WB_ACK_O !== 1'h1);
        rd = WB_DAT_O;
        WB_CYC_I <= 1'h0;
        WB_STB_I <= 1'h0;
        @(posedge REF_CLK);
    endtask : wb

    task automatic rdchk(input string nm, input logic [3:0] a, input logic [7:0] e);
        wb(1'h0, a, 8'h00);
        chk(nm, rd, {24'h000000, e});
    endtask : rdchk

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // ==========================================================
    // Main sequence
    initial begin
        row_t       r;
        int         nb;
        RST = 1'h1;
        {WB_CYC_I, WB_STB_I, WB_WE_I} = 3'h0;
        WB_ADR_I = 4'h0;
        WB_SEL_I = 4'hF;
        WB_DAT_I = 32'h00000000;
        SAMPLE_TICK = 1'h0;
        repeat (6) @(posedge REF_CLK);
        RST <= 1'h0;
        @(posedge REF_CLK);
        foreach (rows[i]) begin
            r = rows[i];
            nb = (r.csz == CSZ_NINE) ? 9 : 32'(r.csz) + 5;
            wb(1'h1, ADR_FORMAT, {2'h0, r.par, r.odd, 1'h0, r.csz[1:0], 1'h0});
            wb(1'h1, ADR_CONTROL, {3'h0, 1'h1, 1'h0, r.csz[2], 2'h0});
            wb(1'h1, ADR_STATUS, {6'h00, r.ds, 1'h0});
            i_tx.send(r.d, nb, r.par, r.odd, r.bad, r.stp, r.ds ? 8 : 16);
            chk("irq", {31'h0, RXC_IRQ}, 32'h0);
            rdchk("status", ADR_STATUS, r.est);
            wb(1'h0, ADR_CONTROL, 8'h00);
            chk("ninth", rd & 32'h2, {30'h0, r.e9, 1'h0});
            rdchk("data", ADR_DATA, r.edat);
            rdchk("empty", ADR_STATUS, {6'h00, r.ds, 1'h0});
            $display("test row %0d done", i);
        end
        // Overrun: two buffered, third waiting, fourth start
        wb(1'h1, ADR_FORMAT, 8'h06);
        wb(1'h1, ADR_STATUS, 8'h00);
        wb(1'h1, ADR_CONTROL, 8'h90);
        for (int k = 1; k <= 4; k++) begin
            i_tx.send(9'(k * 17), 8, 1'h0, 1'h0, 1'h0, 1'h1, 16);
        end
        chk("irq", {31'h0, RXC_IRQ}, 32'h1);
        for (int k = 0; k < 3; k++) begin
            rdchk("status", ADR_STATUS, (k == 2) ? 8'h88 : 8'h80);
            rdchk("data", ADR_DATA, (k == 2) ? 8'h44 : 8'((k + 1) * 17));
        end
        rdchk("status", ADR_STATUS, 8'h00);
        chk("irq", {31'h0, RXC_IRQ}, 32'h0);
        i_tx.send(9'h055, 8, 1'h0, 1'h0, 1'h0, 1'h1, 16);
        rdchk("status", ADR_STATUS, 8'h80);
        rdchk("data", ADR_DATA, 8'h55);
        $display("test overrun done");
        // Flag write refused, then disable in mid-frame
        i_tx.send(9'h066, 8, 1'h0, 1'h0, 1'h0, 1'h0, 16);
        wb(1'h1, ADR_STATUS, 8'h1C);
        rdchk("status", ADR_STATUS, 8'h90);
        fork
            i_tx.send(9'h077, 8, 1'h0, 1'h0, 1'h0, 1'h1, 16);
        join_none
        repeat (100) @(posedge REF_CLK);
        wb(1'h1, ADR_CONTROL, 8'h00);
        chk("owns", {31'h0, RX_OWNS_PIN}, 32'h0);
        rdchk("status", ADR_STATUS, 8'h00);
        wait fork;
        wb(1'h1, ADR_CONTROL, 8'h10);
        chk("owns", {31'h0, RX_OWNS_PIN}, 32'h1);
        rdchk("status", ADR_STATUS, 8'h00);
        // Noise pulse rejected, following frame realigned
        i_tx.glitch(5);
        rdchk("status", ADR_STATUS, 8'h00);
        i_tx.send(9'h03C, 8, 1'h0, 1'h0, 1'h0, 1'h1, 16);
        rdchk("data", ADR_DATA, 8'h3C);
        $display("test disable and noise done");
        // Reset in mid-run with a frame buffered
        i_tx.send(9'h05A, 8, 1'h0, 1'h0, 1'h0, 1'h1, 16);
        RST <= 1'h1;
        repeat (6) @(posedge REF_CLK);
        RST <= 1'h0;
        @(posedge REF_CLK);
        chk("owns", {31'h0, RX_OWNS_PIN}, 32'h0);
        rdchk("status", ADR_STATUS, {6'h00, DSPEED_RST, 1'h0});
        rdchk("control", ADR_CONTROL, CTL_RESET);
        rdchk("format", ADR_FORMAT, FMT_RESET);
        rdchk("unmapped", 4'h2, 8'h00);
        $display("test reset done");
        test_done();
    end
endmodule : uart_rx_tb_top
